// *** paged_data_space_regs.vh ***
// constants for the paged data space address generator
`ifndef PAGED_DATA_SPACE_REGS_VH
`define PAGED_DATA_SPACE_REGS_VH

// special-function region word addresses of the two page registers
`define DATA_READ_PAGE_ADDR 16'h0032
`define DATA_WRITE_PAGE_ADDR 16'h0034

// page register widths
`define DATA_READ_PAGE_W 10
`define DATA_WRITE_PAGE_W 9

// reset values of the page registers
`define DATA_READ_PAGE_RST 10'h001
`define DATA_WRITE_PAGE_RST 9'h001

// field positions
`define EA_PAGE_SEL_BIT 15
`define RD_PAGE_WINDOW_BIT 9
`define EA_LOW_W 15
`define XADDR_W 24

// program memory layout
`define PROG_WORD_W 24
`define PROG_STEP 24'h000002
`define PROG_UPPER_PAD 8'h00

`endif

// *** page_reg_file.v ***
// page register pair with byte-lane writes from the special-function region
`timescale 1ns/1ns
`default_nettype none
`include "paged_data_space_regs.vh"

module page_reg_file (
	input wire mclk_in, // core clock
	input wire rst_in, // synchronous reset, active high
	input wire rd_page_sel_in, // write targets the read page register
	input wire wr_page_sel_in, // write targets the write page register
	input wire wr_en_in, // register write strobe
	input wire [1:0] be_in, // byte enables, bit 0 is the low byte
	input wire [15:0] wdata_in, // write data
	output reg [`DATA_READ_PAGE_W-1:0] rd_page_out, // read page register
	output reg [`DATA_WRITE_PAGE_W-1:0] wr_page_out // write page register
);

	wire [15:0] rd_cur;
	wire [15:0] wr_cur;
	wire [15:0] rd_merge;
	wire [15:0] wr_merge;

	assign rd_cur = {6'h00, rd_page_out};
	assign wr_cur = {7'h00, wr_page_out};

	// per-lane merge so a byte write leaves the other lane alone
	genvar lane;
	generate
		for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
			assign rd_merge[lane*8 +: 8] = be_in[lane] ? wdata_in[lane*8 +: 8] : rd_cur[lane*8 +: 8];
			assign wr_merge[lane*8 +: 8] = be_in[lane] ? wdata_in[lane*8 +: 8] : wr_cur[lane*8 +: 8];
		end
	endgenerate

	// bits above the implemented width are dropped on write
	always @(posedge mclk_in) begin
		if (rst_in) begin
			rd_page_out <= `DATA_READ_PAGE_RST;
			wr_page_out <= `DATA_WRITE_PAGE_RST;
		end else if (wr_en_in) begin
			if (rd_page_sel_in) begin
				rd_page_out <= rd_merge[`DATA_READ_PAGE_W-1:0];
			end
			if (wr_page_sel_in) begin
				wr_page_out <= wr_merge[`DATA_WRITE_PAGE_W-1:0];
			end
		end
	end

endmodule
`default_nettype wire

// *** prog_addr_step.v ***
// program address counter aligned on the lower word, stepping by two
`timescale 1ns/1ns
`default_nettype none
`include "paged_data_space_regs.vh"

module prog_addr_step (
	input wire mclk_in, // core clock
	input wire rst_in, // synchronous reset, active high
	input wire load_in, // load a new program address
	input wire [`XADDR_W-1:0] load_addr_in, // address to load
	input wire step_in, // advance one location
	input wire down_in, // step downward instead of upward
	output reg [`XADDR_W-1:0] pc_out // current program address
);

	reg [`XADDR_W-1:0] pc_nxt;

	// load beats step; bit 0 is forced low so the counter never sits on an upper word
	always @* begin
		pc_nxt = pc_out;
		if (load_in) begin
			pc_nxt = {load_addr_in[`XADDR_W-1:1], 1'b0};
		end else if (step_in) begin
			if (down_in) begin
				pc_nxt = pc_out - `PROG_STEP;
			end else begin
				pc_nxt = pc_out + `PROG_STEP;
			end
		end
	end

	// wraps at the top of the 24-bit space, no trap here
	always @(posedge mclk_in) begin
		if (rst_in) begin
			pc_out <= {`XADDR_W{1'b0}};
		end else begin
			pc_out <= pc_nxt;
		end
	end

endmodule
`default_nettype wire

// *** paged_data_space_address_gen.v ***
// paged data space address generator with program memory word view
// Functional notes
// - ten-bit read page register extends read addresses beyond base space
// - nine-bit write page register extends write addresses beyond base space
// - read page top bit clear and address bit 15 set: page joins low fifteen bits
// - address bit 15 set on write: write page joins low fifteen bits
// - paging applies to pre- and post-modified addresses alike, linearly
// - both page registers sit in the special-function region, readable and writable
// - program location is 24 bits: lower word, upper word, upper byte unimplemented
// - lower word at even address, upper word at next odd address
// - program addresses aligned to lower word, step up or down by two
`timescale 1ns/1ns
`default_nettype none
`include "paged_data_space_regs.vh"

module paged_data_space_address_gen (
	input wire mclk_in, // core clock, 250 MHz
	input wire rst_in, // synchronous reset, active high
	// data access from the effective address path
	input wire acc_valid_in, // access request this cycle
	input wire acc_write_in, // 1 write, 0 read
	input wire [15:0] ptr_in, // pointer register value
	input wire [15:0] mod_in, // pointer modifier, two's complement
	input wire pre_mod_in, // use the modified pointer for this access
	input wire post_mod_in, // modify the pointer after the access
	// special-function region access
	input wire sfr_wr_in, // register write strobe
	input wire sfr_rd_in, // register read strobe
	input wire [15:0] sfr_addr_in, // register address
	input wire [1:0] sfr_be_in, // byte enables for writes
	input wire [15:0] sfr_wdata_in, // register write data
	output reg [15:0] sfr_rdata_out, // register read data
	output reg sfr_ack_out, // access hit one of the page registers
	// addresses toward the paged data memory
	output reg rd_valid_out, // read address valid
	output reg [`XADDR_W-1:0] rd_addr_out, // 24-bit read address
	output reg rd_extended_out, // read went through the read page with its window bit clear
	output reg rd_window_out, // read page selected the program space window
	output reg wr_valid_out, // write address valid
	output reg [`XADDR_W-1:0] wr_addr_out, // 24-bit write address
	output reg wr_extended_out, // write went through the write page
	output reg ptr_upd_valid_out, // updated pointer valid
	output reg [15:0] ptr_upd_out, // pointer after modification
	// program memory
	input wire pc_load_in, // load program address
	input wire [`XADDR_W-1:0] pc_load_addr_in, // address to load
	input wire pc_step_in, // step program address
	input wire pc_down_in, // step downward
	output wire [`XADDR_W-1:0] pc_out, // current program address
	input wire prog_rd_in, // read a program word as data
	input wire [`XADDR_W-1:0] prog_addr_in, // program word address
	input wire [`PROG_WORD_W-1:0] prog_word_in, // 24-bit location contents
	output reg prog_half_valid_out, // program half word valid
	output reg [15:0] prog_half_out // selected half of the location
);

	wire [`DATA_READ_PAGE_W-1:0] rd_page;
	wire [`DATA_WRITE_PAGE_W-1:0] wr_page;
	wire sel_rd_page;
	wire sel_wr_page;
	wire sfr_hit;
	wire reg_wr_en;
	wire [15:0] ea_mod;
	wire [15:0] ea;
	wire ea_paged;
	wire rd_page_direct;

	reg [`XADDR_W-1:0] rd_addr_nxt;
	reg rd_ext_nxt;
	reg rd_win_nxt;
	reg [`XADDR_W-1:0] wr_addr_nxt;
	reg wr_ext_nxt;
	reg [15:0] sfr_rdata_nxt;
	reg [15:0] prog_half_nxt;

	// address decode for the two page registers
	assign sel_rd_page = (sfr_addr_in == `DATA_READ_PAGE_ADDR);
	assign sel_wr_page = (sfr_addr_in == `DATA_WRITE_PAGE_ADDR);
	assign sfr_hit = sel_rd_page | sel_wr_page;
	assign reg_wr_en = sfr_wr_in & sfr_hit;

	page_reg_file u_page_regs (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.rd_page_sel_in(sel_rd_page),
		.wr_page_sel_in(sel_wr_page),
		.wr_en_in(reg_wr_en),
		.be_in(sfr_be_in),
		.wdata_in(sfr_wdata_in),
		.rd_page_out(rd_page),
		.wr_page_out(wr_page)
	);

	prog_addr_step u_prog_step (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.load_in(pc_load_in),
		.load_addr_in(pc_load_addr_in),
		.step_in(pc_step_in),
		.down_in(pc_down_in),
		.pc_out(pc_out)
	);

	// pre-modify uses the sum, post-modify uses the old pointer; both go the same paging path
	assign ea_mod = ptr_in + mod_in;
	assign ea = pre_mod_in ? ea_mod : ptr_in;
	assign ea_paged = ea[`EA_PAGE_SEL_BIT];
	assign rd_page_direct = ~rd_page[`RD_PAGE_WINDOW_BIT];

	// read address: page bits above the low fifteen, base address untouched below the line
	always @* begin
		rd_addr_nxt = {8'h00, ea};
		rd_ext_nxt = 1'b0;
		rd_win_nxt = 1'b0;
		if (ea_paged) begin
			if (rd_page_direct) begin
				rd_addr_nxt = {rd_page[8:0], ea[`EA_LOW_W-1:0]};
				rd_ext_nxt = 1'b1;
			end else begin
				// program space window page: same join, flagged so memory steers to flash
				rd_addr_nxt = {rd_page[8:0], ea[`EA_LOW_W-1:0]};
				rd_win_nxt = 1'b1;
			end
		end else begin
			rd_addr_nxt = {8'h00, ea};
		end
	end

	// write address: the write page has no window bit, so bit 15 alone decides
	always @* begin
		wr_addr_nxt = {8'h00, ea};
		wr_ext_nxt = 1'b0;
		if (ea_paged) begin
			wr_addr_nxt = {wr_page, ea[`EA_LOW_W-1:0]};
			wr_ext_nxt = 1'b1;
		end else begin
			wr_addr_nxt = {8'h00, ea};
		end
	end

	// access outputs, one cycle after the request; a page write in the same cycle is not seen yet
	always @(posedge mclk_in) begin
		if (rst_in) begin
			rd_valid_out <= 1'b0;
			rd_addr_out <= {`XADDR_W{1'b0}};
			rd_extended_out <= 1'b0;
			rd_window_out <= 1'b0;
			wr_valid_out <= 1'b0;
			wr_addr_out <= {`XADDR_W{1'b0}};
			wr_extended_out <= 1'b0;
		end else begin
			rd_valid_out <= acc_valid_in & ~acc_write_in;
			wr_valid_out <= acc_valid_in & acc_write_in;
			if (acc_valid_in & ~acc_write_in) begin
				rd_addr_out <= rd_addr_nxt;
				rd_extended_out <= rd_ext_nxt;
				rd_window_out <= rd_win_nxt;
			end
			if (acc_valid_in & acc_write_in) begin
				wr_addr_out <= wr_addr_nxt;
				wr_extended_out <= wr_ext_nxt;
			end
		end
	end

	// pointer write-back; wraps in 16 bits, so a post-increment past the top drops back below bit 15, out of the window
	always @(posedge mclk_in) begin
		if (rst_in) begin
			ptr_upd_valid_out <= 1'b0;
			ptr_upd_out <= 16'h0000;
		end else begin
			ptr_upd_valid_out <= acc_valid_in & (pre_mod_in | post_mod_in);
			if (acc_valid_in & (pre_mod_in | post_mod_in)) begin
				ptr_upd_out <= ea_mod;
			end
		end
	end

	// read-back of the page registers, unimplemented upper bits read as zero
	always @* begin
		sfr_rdata_nxt = 16'h0000;
		if (sel_rd_page) begin
			sfr_rdata_nxt = {6'h00, rd_page};
		end else if (sel_wr_page) begin
			sfr_rdata_nxt = {7'h00, wr_page};
		end
	end

	// read data registered; ack marks a hit so other region decoders can stay quiet
	always @(posedge mclk_in) begin
		if (rst_in) begin
			sfr_rdata_out <= 16'h0000;
			sfr_ack_out <= 1'b0;
		end else begin
			sfr_ack_out <= (sfr_rd_in | sfr_wr_in) & sfr_hit;
			if (sfr_rd_in & sfr_hit) begin
				sfr_rdata_out <= sfr_rdata_nxt;
			end else begin
				sfr_rdata_out <= 16'h0000;
			end
		end
	end

	// odd address gives the upper word, whose top byte does not exist and reads as zero
	always @* begin
		if (prog_addr_in[0]) begin
			prog_half_nxt = {`PROG_UPPER_PAD, prog_word_in[23:16]};
		end else begin
			prog_half_nxt = prog_word_in[15:0];
		end
	end

	// program half word register
	always @(posedge mclk_in) begin
		if (rst_in) begin
			prog_half_valid_out <= 1'b0;
			prog_half_out <= 16'h0000;
		end else begin
			prog_half_valid_out <= prog_rd_in;
			if (prog_rd_in) begin
				prog_half_out <= prog_half_nxt;
			end
		end
	end

endmodule
`default_nettype wire

// *** paged_data_space_address_gen_checker.sv ***
// port-level assertions for the paged data space address generator
`timescale 1ns/1ns
`default_nettype none
`include "paged_data_space_regs.vh"
module paged_data_space_address_gen_checker (
	input wire logic mclk_in, rst_in, acc_valid_in, acc_write_in, pre_mod_in,
	input wire logic [15:0] ptr_in, mod_in, sfr_addr_in, prog_half_out,
	input wire logic sfr_wr_in, sfr_rd_in, sfr_ack_out, rd_valid_out, rd_extended_out,
	input wire logic wr_valid_out, wr_extended_out, pc_load_in, pc_step_in, pc_down_in,
	input wire logic prog_rd_in, prog_half_valid_out,
	input wire logic [23:0] rd_addr_out, wr_addr_out, pc_out, prog_addr_in, prog_word_in
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// effective address as the access path forms it
	wire logic [15:0] ea = pre_mod_in ? ptr_in + mod_in : ptr_in;
	wire logic rd_acc = acc_valid_in && !acc_write_in;
	wire logic wr_acc = acc_valid_in && acc_write_in;
	wire logic hit = (sfr_wr_in || sfr_rd_in) &&
		(sfr_addr_in == `DATA_READ_PAGE_ADDR || sfr_addr_in == `DATA_WRITE_PAGE_ADDR);
	logic [15:0] ea_q;
	logic [23:0] word_q;
	// keep request values so the answer one cycle on can be compared
	always @(posedge mclk_in) begin
		ea_q <= ea;
		word_q <= prog_word_in;
	end
	a_rd_base_pass: assert property (rd_acc && !ea[15] |=> rd_valid_out && !rd_extended_out
		&& rd_addr_out == {8'h00, ea_q}) else $error("base read address wrong");
	a_rd_page_low: assert property (rd_acc && ea[15] |=> rd_valid_out
		&& rd_addr_out[14:0] == ea_q[14:0]) else $error("paged read address wrong");
	a_wr_page_join: assert property (wr_acc && ea[15] |=> wr_valid_out && wr_extended_out
		&& wr_addr_out[14:0] == ea_q[14:0]) else $error("paged write address wrong");
	a_wr_base_pass: assert property (wr_acc && !ea[15] |=> wr_valid_out && !wr_extended_out
		&& wr_addr_out == {8'h00, ea_q}) else $error("base write address wrong");
	a_sfr_ack_hit: assert property (hit |=> sfr_ack_out) else $error("page access not acked");
	a_sfr_ack_miss: assert property (!hit |=> !sfr_ack_out) else $error("stray ack");
	a_pc_step_up: assert property (pc_step_in && !pc_load_in && !pc_down_in
		|=> pc_out == $past(pc_out) + 24'h000002) else $error("upward step not two");
	a_pc_step_down: assert property (pc_step_in && !pc_load_in && pc_down_in
		|=> pc_out == $past(pc_out) - 24'h000002) else $error("downward step not two");
	a_prog_upper_half: assert property (prog_rd_in && prog_addr_in[0] |=> prog_half_valid_out
		&& prog_half_out == {8'h00, word_q[23:16]}) else $error("odd half wrong");
	a_prog_lower_half: assert property (prog_rd_in && !prog_addr_in[0] |=> prog_half_valid_out
		&& prog_half_out == word_q[15:0]) else $error("even half wrong");
endmodule
bind paged_data_space_address_gen paged_data_space_address_gen_checker chk_inst (.*);
`default_nettype wire

// *** paged_mem_model.sv ***
// paged data memory model that latches the stores it is handed
`timescale 1ns/1ns
`default_nettype none
module paged_mem_model (
	input wire logic mclk_in, // core clock
	input wire logic wr_valid_in, // store address valid
	input wire logic wr_ext_in, // store went through the write page
	input wire logic [23:0] wr_addr_in, // store address
	output logic [7:0] ext_cnt_out, // stores above the base space
	output logic [23:0] last_addr_out // latest store address
);
	initial ext_cnt_out = 8'h00;
	initial last_addr_out = 24'h000000;
	// the memory ignores an address that is not flagged valid
	always @(posedge mclk_in) begin
		if (wr_valid_in) begin
			last_addr_out <= wr_addr_in;
			if (wr_ext_in) ext_cnt_out <= ext_cnt_out + 8'h01;
		end
	end
endmodule
`default_nettype wire

// *** paged_data_space_address_gen_bench.sv ***
// testbench for the paged data space address generator
`timescale 1ns/1ns
`default_nettype none
module paged_data_space_address_gen_bench;
	logic mclk_in, rst_in, acc_valid_in, acc_write_in, pre_mod_in, post_mod_in, sfr_wr_in;
	logic sfr_rd_in, pc_load_in, pc_step_in, pc_down_in, prog_rd_in;
	logic [15:0] ptr_in, mod_in, sfr_addr_in, sfr_wdata_in;
	logic [1:0] sfr_be_in;
	logic [23:0] pc_load_addr_in, prog_addr_in, prog_word_in;
	wire logic sfr_ack_out, rd_valid_out, rd_extended_out, rd_window_out, wr_valid_out;
	wire logic wr_extended_out, ptr_upd_valid_out, prog_half_valid_out;
	wire logic [15:0] sfr_rdata_out, ptr_upd_out, prog_half_out;
	wire logic [23:0] rd_addr_out, wr_addr_out, pc_out, last_addr;
	wire logic [7:0] ext_cnt;
	int errors = 0, checked = 0, cycles = 0;
	paged_data_space_address_gen paged_data_space_address_gen_inst (.mclk_in, .rst_in,
		.acc_valid_in, .acc_write_in, .ptr_in, .mod_in, .pre_mod_in, .post_mod_in, .sfr_wr_in,
		.sfr_rd_in, .sfr_addr_in, .sfr_be_in, .sfr_wdata_in, .sfr_rdata_out, .sfr_ack_out,
		.rd_valid_out, .rd_addr_out, .rd_extended_out, .rd_window_out, .wr_valid_out,
		.wr_addr_out, .wr_extended_out, .ptr_upd_valid_out, .ptr_upd_out, .pc_load_in,
		.pc_load_addr_in, .pc_step_in, .pc_down_in, .pc_out, .prog_rd_in, .prog_addr_in,
		.prog_word_in, .prog_half_valid_out, .prog_half_out);
	paged_mem_model paged_mem_model_inst (.mclk_in(mclk_in), .wr_valid_in(wr_valid_out),
		.wr_ext_in(wr_extended_out), .wr_addr_in(wr_addr_out), .ext_cnt_out(ext_cnt),
		.last_addr_out(last_addr));
	initial mclk_in = 1'b0;
	always #2 mclk_in = ~mclk_in;
	task automatic end_sim;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// a hang costs one mismatch; the whole run needs about fifty cycles
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			end_sim;
		end
	end
	task automatic chk(input string n, input logic [23:0] e, g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkb(input string n, input logic e, g);
		chk(n, {23'h0, e}, {23'h0, g});
	endtask
	// register access: ack and read data come together one cycle on
	task automatic special_function_region(input logic w, input logic [15:0] a, input logic [1:0] be,
		input logic [15:0] d, input logic [16:0] e);
		@(negedge mclk_in);
		{sfr_wr_in, sfr_rd_in, sfr_addr_in, sfr_be_in, sfr_wdata_in} = {w, !w, a, be, d};
		@(negedge mclk_in);
		{sfr_wr_in, sfr_rd_in} = 2'h0;
		chk("sfr", {7'h00, e}, {7'h00, sfr_ack_out, sfr_rdata_out});
	endtask
	task automatic acc(input logic w, input logic [15:0] p, m, input logic pr, po,
		input logic [23:0] e);
		@(negedge mclk_in);
		{acc_valid_in, acc_write_in, ptr_in, mod_in, pre_mod_in, post_mod_in} = {1'b1, w, p, m, pr, po};
		@(negedge mclk_in);
		acc_valid_in = 1'b0;
		chkb("valid", 1'b1, w ? wr_valid_out : rd_valid_out);
		chk("addr", e, w ? wr_addr_out : rd_addr_out);
	endtask
	task automatic pcop(input logic ld, st, dn, input logic [23:0] a, e);
		@(negedge mclk_in);
		{pc_load_in, pc_step_in, pc_down_in, pc_load_addr_in} = {ld, st, dn, a};
		@(negedge mclk_in);
		{pc_load_in, pc_step_in} = 2'h0;
		chk("pc", e, pc_out);
	endtask
	task automatic half(input logic [23:0] a, input logic [15:0] e);
		@(negedge mclk_in);
		{prog_rd_in, prog_addr_in, prog_word_in} = {1'b1, a, 24'hABCDEF};
		@(negedge mclk_in);
		prog_rd_in = 1'b0;
		chk("prog_half", {8'h01, e}, {7'h00, prog_half_valid_out, prog_half_out});
	endtask
	initial begin
		{acc_valid_in, acc_write_in, pre_mod_in, post_mod_in, sfr_wr_in, sfr_rd_in} = 6'h00;
		{ptr_in, mod_in, sfr_addr_in, sfr_wdata_in, sfr_be_in} = 66'h0;
		{pc_load_in, pc_step_in, pc_down_in, prog_rd_in} = 4'h0;
		{pc_load_addr_in, prog_addr_in, prog_word_in} = 72'h0;
		rst_in = 1'b1;
		repeat (8) @(posedge mclk_in);
		@(negedge mclk_in);
		rst_in = 1'b0;
		special_function_region(0, 16'h0032, 2'h3, 16'h0000, 17'h10001);
		special_function_region(0, 16'h0034, 2'h3, 16'h0000, 17'h10001);
		special_function_region(0, 16'h0036, 2'h3, 16'h0000, 17'h00000);
		special_function_region(1, 16'h0034, 2'h3, 16'hFFFF, 17'h10000);
		special_function_region(0, 16'h0034, 2'h3, 16'h0000, 17'h101FF);
		special_function_region(1, 16'h0032, 2'h1, 16'hFF55, 17'h10000);
		special_function_region(1, 16'h0032, 2'h2, 16'h0100, 17'h10000);
		special_function_region(0, 16'h0032, 2'h3, 16'h0000, 17'h10155);
		$display("register test done");
		acc(0, 16'h9234, 16'h0002, 0, 0, 24'hAA9234);
		chkb("rd_ext", 1'b1, rd_extended_out);
		acc(0, 16'h1234, 16'h0000, 0, 0, 24'h001234);
		chkb("rd_ext", 1'b0, rd_extended_out);
		acc(0, 16'h7FFE, 16'h0002, 1, 0, 24'hAA8000);
		acc(0, 16'h7FFE, 16'h0002, 0, 1, 24'h007FFE);
		chk("ptr_upd", 24'h018000, {7'h00, ptr_upd_valid_out, ptr_upd_out});
		acc(1, 16'hFFFF, 16'h0000, 0, 0, 24'hFFFFFF);
		chkb("wr_ext", 1'b1, wr_extended_out);
		acc(1, 16'h0010, 16'h0000, 0, 0, 24'h000010);
		// the memory takes the store on the edge after wr_valid_out rises, so let one pass
		@(negedge mclk_in);
		chk("mem_ext", 24'h000001, {16'h0000, ext_cnt});
		chk("mem_addr", 24'h000010, last_addr);
		special_function_region(1, 16'h0032, 2'h3, 16'h03FF, 17'h10000);
		acc(0, 16'h8001, 16'h0000, 0, 0, 24'hFF8001);
		chkb("rd_win", 1'b1, rd_window_out);
		chkb("rd_ext", 1'b0, rd_extended_out);
		$display("data address test done");
		pcop(1, 0, 0, 24'h000101, 24'h000100);
		pcop(0, 1, 0, 24'h000000, 24'h000102);
		pcop(0, 1, 1, 24'h000000, 24'h000100);
		pcop(0, 1, 1, 24'h000000, 24'h0000FE);
		half(24'h000002, 16'hCDEF);
		half(24'h000003, 16'h00AB);
		$display("program memory test done");
		end_sim;
	end
endmodule
`default_nettype wire
